// ==== pkg/acc_pkg.sv ====
// Constants for the converter start/abort control block.
// Assumes a single 10 MHz core clock and a plain register port.
package acc_pkg;

    // Register offsets (byte addresses on the register port)
    localparam logic [3:0] ACC_OFS_CTRL0  = 4'h0;
    localparam logic [3:0] ACC_OFS_RESLO  = 4'h1;
    localparam logic [3:0] ACC_OFS_RESHI  = 4'h2;
    localparam logic [3:0] ACC_OFS_PREVLO = 4'h3;
    localparam logic [3:0] ACC_OFS_PREVHI = 4'h4;
    localparam logic [3:0] ACC_OFS_STAT   = 4'h5;
    localparam logic [3:0] ACC_OFS_MASK   = 4'h6;

    // Control register zero field positions
    localparam int ACC_BIT_ON         = 7;
    localparam int ACC_BIT_CONTINUOUS = 6;
    localparam int ACC_BIT_CS         = 4;
    localparam int ACC_BIT_FORMAT     = 2;
    localparam int ACC_BIT_GO         = 0;
    localparam logic [7:0] ACC_CTRL0_RST   = 8'h00;
    localparam logic [7:0] ACC_CTRL0_WMASK = 8'hD4;

    // Status/mask field positions
    localparam int ACC_ST_DONE  = 0;
    localparam int ACC_ST_THR   = 1;
    localparam int ACC_ST_ABORT = 2;
    localparam int ACC_ST_W     = 3;

    // Converter geometry and timing
    localparam int ACC_RES_W      = 12;
    localparam int ACC_SAMPLE_CYC = 4;

    // Sequencer states
    typedef enum logic [1:0] {ACC_IDLE, ACC_SAMPLE, ACC_CONVERT, ACC_POST} acc_state_t;

endpackage

// ==== verilog/acc_justify.sv ====
// Result justification for conversion result and previous-result words.
// Assumes a raw right-aligned code of RES_W bits, output as 16 bits.
`timescale 1ns/10ps
`default_nettype none
module acc_justify #(
    parameter int RES_W = 12
) (
    input  wire logic [RES_W-1:0] raw,
    input  wire logic             right_fmt,
    output logic      [15:0]      just
);
    // Right: zero-extend high; left: shift up, zero-fill low bits
    wire [15:0] right_w = {{(16-RES_W){1'b0}}, raw};
    wire [15:0] left_w  = {raw, {(16-RES_W){1'b0}}};
    assign just = right_fmt ? right_w : left_w;
endmodule // acc_justify
`default_nettype wire

// ==== verilog/acc_ctrl.sv ====
// Converter conversion start/abort control with register port and interrupt.
// Assumes the analog core returns one result bit per cycle (successive
// approximation) on cmp_in; threshold logic outside reports thr_hit.
//
// How it works
// - Format bit one right-justifies result and previous, zero left-justifies zero-filled.
// - Writing one to go starts a conversion; go reads one while in progress.
// - Hardware clears go at cycle end, timing governed by continuous mode.
// - Software clearing go mid-conversion copies the partial result into result.
// - Software abort returns the sequencer to its idle state.
// - Aborted conversion never sets the conversion-complete interrupt flag.
// - Aborted conversion skips filter computation and threshold comparison.
// - Continuous mode re-arms go until threshold flag with stop-on-interrupt, or clear.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module acc_ctrl
    import acc_pkg::*;
#(
    parameter int RES_W      = ACC_RES_W,
    parameter int SAMPLE_CYC = ACC_SAMPLE_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    input  wire logic        cmp_in,
    input  wire logic        thr_hit,
    input  wire logic        stop_on_interrupt_bit,
    output logic             sample_en,
    output logic             post_calc,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    wire wr_ctrl = wr && (addr == ACC_OFS_CTRL0);
    wire wr_mask = wr && (addr == ACC_OFS_MASK);
    wire rd_stat = rd && (addr == ACC_OFS_STAT);

    logic [7:0]          ctrl_q;
    logic                go_q;
    logic [RES_W-1:0]    sar_q;
    logic [RES_W-1:0]    res_q;
    logic [RES_W-1:0]    prev_q;
    logic [ACC_ST_W-1:0] stat_q;
    logic [ACC_ST_W-1:0] mask_q;
    logic [7:0]          rdata_q;
    logic [7:0]          cnt_q;
    acc_state_t          state_q;

    wire on_bit              = ctrl_q[ACC_BIT_ON];
    wire continuous_mode_bit = ctrl_q[ACC_BIT_CONTINUOUS];
    wire result_format_bit   = ctrl_q[ACC_BIT_FORMAT];

    // Go set and software clear; go needs converter enabled
    wire go_set   = wr_ctrl && wdata[ACC_BIT_GO] && wdata[ACC_BIT_ON];
    wire sw_clear = wr_ctrl && !wdata[ACC_BIT_GO] && go_q;
    wire abort    = sw_clear && (state_q != ACC_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer events
    wire last_bit  = (state_q == ACC_CONVERT) && (cnt_q == 8'(RES_W - 1));
    wire samp_done = (state_q == ACC_SAMPLE) && (cnt_q == 8'(SAMPLE_CYC - 1));
    wire finish    = (state_q == ACC_POST) && !abort;
    wire thr_event = finish && thr_hit;
    // Continuous re-arm unless threshold stop requested
    wire rearm     = continuous_mode_bit && !(thr_event && stop_on_interrupt_bit);
    wire [RES_W-1:0] sar_next = {sar_q[RES_W-2:0], cmp_in};

    assign sample_en = (state_q == ACC_SAMPLE);
    assign post_calc = finish;
    assign irq       = |(stat_q & mask_q);

    // Control register, go flag held separately
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= ACC_CTRL0_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= wdata & ACC_CTRL0_WMASK;
        end
    end

    // Go flag: set by software, cleared by a software write of zero, by turning the converter off, or by hardware at end unless continuous mode re-arms it
    always_ff @(posedge clk) begin
        if (rst) begin
            go_q <= 1'b0;
        end else if (go_set) begin
            go_q <= 1'b1;
        end else if (sw_clear || !on_bit) begin
            go_q <= 1'b0;
        end else if (finish) begin
            go_q <= rearm;
        end
    end

    // Sequencer state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ACC_IDLE;
            cnt_q   <= 8'h00;
        end else if (abort || !on_bit) begin
            state_q <= ACC_IDLE;
            cnt_q   <= 8'h00;
        end else begin
            unique case (state_q)
                ACC_IDLE: begin
                    cnt_q <= 8'h00;
                    // A clear landing on the idle cycle must not start a run
                    if (go_q && !sw_clear) begin
                        state_q <= ACC_SAMPLE;
                    end
                end
                ACC_SAMPLE: begin
                    cnt_q <= samp_done ? 8'h00 : cnt_q + 8'h01;
                    if (samp_done) begin
                        state_q <= ACC_CONVERT;
                    end
                end
                ACC_CONVERT: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (last_bit) begin
                        state_q <= ACC_POST;
                    end
                end
                ACC_POST: begin
                    cnt_q   <= 8'h00;
                    state_q <= ACC_IDLE;
                end
            endcase
        end
    end

    // Successive approximation and result capture
    always_ff @(posedge clk) begin
        if (rst) begin
            sar_q  <= '0;
            res_q  <= '0;
            prev_q <= '0;
        end else begin
            // Cleared before sampling so an early abort reports no bits
            if (state_q == ACC_IDLE || state_q == ACC_SAMPLE) begin
                sar_q <= '0;
            end else if (state_q == ACC_CONVERT) begin
                sar_q <= sar_next;
            end
            if (abort) begin
                res_q <= sar_q;
            end else if (last_bit) begin
                prev_q <= res_q;
                res_q  <= sar_next;
            end
        end
    end

    // Sticky status: set wins over read-clear
    logic [ACC_ST_W-1:0] st_set;
    always_comb begin
        st_set               = '0;
        st_set[ACC_ST_DONE]  = finish;
        st_set[ACC_ST_THR]   = thr_event;
        st_set[ACC_ST_ABORT] = abort;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stat_q <= '0;
            mask_q <= '0;
        end else begin
            stat_q <= (rd_stat ? '0 : stat_q) | st_set;
            if (wr_mask) begin
                mask_q <= wdata[ACC_ST_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path
    logic [15:0] res_j;
    logic [15:0] prev_j;

    acc_justify #(.RES_W(RES_W)) u_just_res (
        .raw       (res_q),
        .right_fmt (result_format_bit),
        .just      (res_j)
    );
    acc_justify #(.RES_W(RES_W)) u_just_prev (
        .raw       (prev_q),
        .right_fmt (result_format_bit),
        .just      (prev_j)
    );

    logic [7:0] rd_mux;
    always_comb begin
        unique case (addr)
            ACC_OFS_CTRL0:  rd_mux = {ctrl_q[7:1], go_q};
            ACC_OFS_RESLO:  rd_mux = res_j[7:0];
            ACC_OFS_RESHI:  rd_mux = res_j[15:8];
            ACC_OFS_PREVLO: rd_mux = prev_j[7:0];
            ACC_OFS_PREVHI: rd_mux = prev_j[15:8];
            ACC_OFS_STAT:   rd_mux = {{(8-ACC_ST_W){1'b0}}, stat_q};
            ACC_OFS_MASK:   rd_mux = {{(8-ACC_ST_W){1'b0}}, mask_q};
            default:        rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd ? rd_mux : 8'h00;
        end
    end
    assign rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    a_abort_no_done: assert property (@(posedge clk) disable iff (rst)
        abort |=> !stat_q[ACC_ST_DONE] || $past(stat_q[ACC_ST_DONE]))
        else $error("abort set done flag");
    a_abort_idle: assert property (@(posedge clk) disable iff (rst)
        abort |=> state_q == ACC_IDLE)
        else $error("abort did not reset sequencer");
    a_abort_result: assert property (@(posedge clk) disable iff (rst)
        abort |=> res_q == $past(sar_q))
        else $error("partial result not copied");
    a_abort_no_post: assert property (@(posedge clk) disable iff (rst)
        abort |-> !post_calc ##1 !post_calc)
        else $error("post processing after abort");
    a_go_start: assert property (@(posedge clk) disable iff (rst)
        (go_set && state_q == ACC_IDLE) ##1 !wr_ctrl |-> go_q ##1 (state_q == ACC_SAMPLE))
        else $error("go did not start conversion");
    a_single_clear: assert property (@(posedge clk) disable iff (rst)
        (finish && !continuous_mode_bit && !go_set && on_bit) |=> !go_q)
        else $error("go not cleared in single mode");
    a_rearm_continuous: assert property (@(posedge clk) disable iff (rst)
        (finish && continuous_mode_bit && !thr_hit && !wr_ctrl) |=> go_q)
        else $error("continuous mode did not re-arm");
    a_go_needs_on: assert property (@(posedge clk) disable iff (rst)
        !on_bit |=> state_q == ACC_IDLE)
        else $error("conversion while disabled");
    a_thr_stop: assert property (@(posedge clk) disable iff (rst)
        (finish && thr_hit && stop_on_interrupt_bit && !wr_ctrl) |=> !go_q)
        else $error("threshold stop did not clear go");
    a_go_while_busy: assert property (@(posedge clk) disable iff (rst)
        (state_q != ACC_IDLE) |-> go_q)
        else $error("go low while sequencer busy");
    a_finish_done: assert property (@(posedge clk) disable iff (rst)
        finish |=> stat_q[ACC_ST_DONE])
        else $error("completed conversion left done clear");

    // Status flags and post-processing pulse
    a_abort_flag: assert property (@(posedge clk) disable iff (rst)
        abort |=> stat_q[ACC_ST_ABORT])
        else $error("abort not flagged");
    a_done_sticky: assert property (@(posedge clk) disable iff (rst)
        (stat_q[ACC_ST_DONE] && !rd_stat) |=> stat_q[ACC_ST_DONE])
        else $error("done flag lost without read");
    a_post_single: assert property (@(posedge clk) disable iff (rst)
        post_calc |=> !post_calc)
        else $error("post processing longer than one cycle");

    // Justified words: unused bits always zero
    a_left_zero_fill: assert property (@(posedge clk) disable iff (rst)
        !result_format_bit |-> (res_j[15-RES_W:0] == '0) && (prev_j[15-RES_W:0] == '0))
        else $error("left-justified word not zero-filled");
    a_right_zero_high: assert property (@(posedge clk) disable iff (rst)
        result_format_bit |-> (res_j[15:RES_W] == '0) && (prev_j[15:RES_W] == '0))
        else $error("right-justified word has high bits set");

endmodule // acc_ctrl
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the converter start/abort control block.
// Assumes acc_pkg offsets and field positions; bench drives all ports.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import acc_pkg::*;
    logic       clk, rst, wr, rd, cmp_in, thr_hit, soi;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, v, lo;
    logic       sample_en, post_calc, irq;
    int         n_errors, cmp_count, n_post, base;

    acc_ctrl uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cmp_in(cmp_in), .thr_hit(thr_hit), .stop_on_interrupt_bit(soi),
        .sample_en(sample_en), .post_calc(post_calc), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, post-cycle counter and watchdog
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (post_calc === 1'b1) n_post++;
    end
    initial begin
        #(100 * 30000);
        n_errors++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus tasks and comparison
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Poll go until hardware drops it, bounded
    task automatic wait_idle();
        int i;
        for (i = 0; i < 100; i++) begin
            rd_reg(ACC_OFS_CTRL0, v);
            if (v[0] === 1'b0) break;
        end
        check({7'h00, v[0]}, 8'h00);
    endtask
    task automatic stop_test();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00;
        cmp_in = 1'b1; thr_hit = 1'b0; soi = 1'b0;
        n_errors = 0; cmp_count = 0; n_post = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_reg(ACC_OFS_CTRL0, v); check(v, ACC_CTRL0_RST);
        rd_reg(4'hF, v); check(v, 8'h00);
        // Go with converter off is ignored
        wr_reg(ACC_OFS_CTRL0, 8'h01);
        rd_reg(ACC_OFS_CTRL0, v); check(v, 8'h00);
        // Single conversion, right-justified, all ones, unmasked done
        wr_reg(ACC_OFS_MASK, 8'h01);
        wr_reg(ACC_OFS_CTRL0, 8'h85);
        rd_reg(ACC_OFS_CTRL0, v); check(v, 8'h85);
        wait_idle();
        check({7'h00, irq}, 8'h01);
        rd_reg(ACC_OFS_RESHI, v); check(v, 8'h0F);
        rd_reg(ACC_OFS_RESLO, v); check(v, 8'hFF);
        rd_reg(ACC_OFS_STAT, v); check(v, 8'h01);
        check({7'h00, irq}, 8'h00);
        // Second conversion of zeros, left-justified; previous holds ones
        cmp_in <= 1'b0;
        wr_reg(ACC_OFS_CTRL0, 8'h81);
        wait_idle();
        rd_reg(ACC_OFS_RESHI, v); check(v, 8'h00);
        rd_reg(ACC_OFS_PREVHI, v); check(v, 8'hFF);
        rd_reg(ACC_OFS_PREVLO, v); check(v, 8'hF0);
        rd_reg(ACC_OFS_STAT, v);
        // Abort in mid-conversion
        cmp_in <= 1'b1;
        wr_reg(ACC_OFS_CTRL0, 8'h85);
        base = n_post;
        repeat (8) @(posedge clk);
        wr_reg(ACC_OFS_CTRL0, 8'h84);
        repeat (2) @(posedge clk);
        check({7'h00, sample_en}, 8'h00);
        rd_reg(ACC_OFS_RESHI, v); check(v, 8'h00);
        rd_reg(ACC_OFS_RESLO, lo);
        check({7'h00, lo != 8'h00 && lo != 8'hFF}, 8'h01);
        rd_reg(ACC_OFS_STAT, v); check(v, 8'h04);
        check({7'h00, irq}, 8'h00);
        repeat (30) @(posedge clk);
        check(n_post[7:0], base[7:0]);
        // Abort in the sample phase: no bits taken, sequencer idle at once
        wr_reg(ACC_OFS_CTRL0, 8'h85);
        wr_reg(ACC_OFS_CTRL0, 8'h84);
        #1 check({7'h00, sample_en}, 8'h00);
        rd_reg(ACC_OFS_RESLO, v); check(v, 8'h00);
        rd_reg(ACC_OFS_STAT, v); check(v, 8'h04);
        repeat (30) @(posedge clk);
        check(n_post[7:0], base[7:0]);
        // Restart runs a full conversion from idle
        wr_reg(ACC_OFS_CTRL0, 8'h85);
        wait_idle();
        rd_reg(ACC_OFS_RESLO, v); check(v, 8'hFF);
        rd_reg(ACC_OFS_STAT, v); check(v, 8'h01);
        // Continuous mode re-arms go, then stops on threshold
        base = n_post;
        wr_reg(ACC_OFS_CTRL0, 8'hC5);
        repeat (120) @(posedge clk);
        check({7'h00, n_post >= base + 2}, 8'h01);
        rd_reg(ACC_OFS_CTRL0, v); check({7'h00, v[0]}, 8'h01);
        soi <= 1'b1; thr_hit <= 1'b1;
        wait_idle();
        rd_reg(ACC_OFS_STAT, v); check(v, 8'h03);
        soi <= 1'b0; thr_hit <= 1'b0;
        // Continuous with software clear of go stops the run
        wr_reg(ACC_OFS_CTRL0, 8'hC5);
        repeat (40) @(posedge clk);
        wr_reg(ACC_OFS_CTRL0, 8'hC4);
        base = n_post;
        repeat (60) @(posedge clk);
        check(n_post[7:0], base[7:0]);
        rd_reg(ACC_OFS_CTRL0, v); check(v, 8'hC4);
        // Turning the converter off drops go
        wr_reg(ACC_OFS_CTRL0, 8'hC5);
        repeat (6) @(posedge clk);
        wr_reg(ACC_OFS_CTRL0, 8'h00);
        rd_reg(ACC_OFS_CTRL0, v); check(v, 8'h00);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
